/* File: rtl/cef_consts.svh */
`ifndef CEF_CONSTS_SVH
`define CEF_CONSTS_SVH
// register offsets of the five event flag bytes
`define CEF_OFS_FLAG1 8'h18
`define CEF_OFS_FLAG2 8'h19
`define CEF_OFS_FLAG3 8'h1A
`define CEF_OFS_FLAG4 8'h1B
`define CEF_OFS_FLAG5 8'h1C
// implemented bits per byte, reserved bits are zero
`define CEF_IMPL_FLAG1 8'hFF
`define CEF_IMPL_FLAG2 8'hF4
`define CEF_IMPL_FLAG3 8'hFF
`define CEF_IMPL_FLAG4 8'hFF
`define CEF_IMPL_FLAG5 8'hD0
// reset value of every flag byte
`define CEF_FLAG_RST 8'h00
// conversion-done position inside the fourth byte
`define CEF_ADC_DONE_BIT 7
// number of flag bytes
`define CEF_NUM_BYTES 5
`endif

/* File: rtl/cef_flag_bank.sv */
// Operation
// - byte 18h holds battery/bus voltage change flags
// - byte 19h bus current flags, bits 3,1,0 zero
// - byte 1Ah input and presence change flags
// - byte 1Bh thermal, ADC, watchdog change flags
// - conversion-done flag sets in one-shot mode only
// - byte 1Ch converter flags, bits 5,3-0 zero
// - flags read-only, one means changed, reset zero
// - flag drives interrupt only while mask bit zero
// - done status forced zero in continuous mode
`include "cef_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module cef_flag_bank #(
  parameter int NUM_BYTES = `CEF_NUM_BYTES
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // live status bytes from comparators, monitors, ADC, watchdog
  input  wire cef_pkg::cef_byte_t stat_bat_bus_volt,
  input  wire cef_pkg::cef_byte_t stat_bus_current,
  input  wire cef_pkg::cef_byte_t stat_input_presence,
  input  wire cef_pkg::cef_byte_t stat_thermal_adc_wd,
  input  wire cef_pkg::cef_byte_t stat_converter,
  // ADC conversion mode, high for one-shot
  input  wire logic              adc_oneshot_mode,
  // interrupt masks, one per flag bit, one blocks
  input  wire cef_pkg::cef_byte_t mask_bat_bus_volt,
  input  wire cef_pkg::cef_byte_t mask_bus_current,
  input  wire cef_pkg::cef_byte_t mask_input_presence,
  input  wire cef_pkg::cef_byte_t mask_thermal_adc_wd,
  input  wire cef_pkg::cef_byte_t mask_converter,
  // register read port behind the serial control port
  input  wire logic              rd_en,
  input  wire cef_pkg::cef_byte_t rd_addr,
  output cef_pkg::cef_byte_t      rd_data,
  // interrupt request, active high
  output logic                   int_req
);
  import cef_pkg::*;

  // implemented bits of the whole bank, byte 0 lowest;
  // reserved positions are cleared here once so that no later logic
  // has to remember which bits of which byte are empty
  localparam logic [39:0] IMPL = {`CEF_IMPL_FLAG5, `CEF_IMPL_FLAG4, `CEF_IMPL_FLAG3,
                                  `CEF_IMPL_FLAG2, `CEF_IMPL_FLAG1};
  localparam int DONE_IDX = 3 * 8 + `CEF_ADC_DONE_BIT; // done bit in the flat vector

  cef_state_t  st_reg;   // registered state
  cef_state_t  st_next;  // next state
  logic [39:0] stat_all; // live status, done bit gated by mode
  logic [39:0] mask_all; // all masks, flat
  logic [39:0] chg;      // synchronised change pulses
  logic [39:0] set_vec;  // flag set requests
  logic [39:0] clr_vec;  // flag clear by read
  logic [2:0]  rd_idx;   // addressed byte index
  logic        rd_hit;   // address within the bank

  // the bank layout is fixed at five bytes
  if (NUM_BYTES != 5) begin : g_chk
    $error("cef_flag_bank: NUM_BYTES must be 5");
  end

  // done status is meaningless in continuous mode, hold it low
  always_comb begin
    stat_all = {stat_converter, stat_thermal_adc_wd, stat_input_presence,
                stat_bus_current, stat_bat_bus_volt};
    stat_all[DONE_IDX] = stat_thermal_adc_wd[`CEF_ADC_DONE_BIT] & adc_oneshot_mode;
    mask_all = {mask_converter, mask_thermal_adc_wd, mask_input_presence,
                mask_bus_current, mask_bat_bus_volt};
  end

  // status lines come from other domains, so three stages each;
  // both edges of a status level count as a change, and a level
  // that holds for less than two clock cycles may be missed
  // trade-off: four cycles of latency buy freedom from metastability
  cef_sync_change #(
    .W (40)
  ) u_sync (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .stat_async (stat_all),
    .chg        (chg)
  );

  // address decode of the five flag bytes;
  // anything else falls through and reads as zero
  // the mask and live status bytes live outside this bank
  always_comb begin
    rd_hit = 1'b1;
    rd_idx = 3'h0;
    case (rd_addr)
      `CEF_OFS_FLAG1: rd_idx = 3'h0;
      `CEF_OFS_FLAG2: rd_idx = 3'h1;
      `CEF_OFS_FLAG3: rd_idx = 3'h2;
      `CEF_OFS_FLAG4: rd_idx = 3'h3;
      `CEF_OFS_FLAG5: rd_idx = 3'h4;
      default:        rd_hit = 1'b0;
    endcase
  end

  // flag update, read answer and interrupt
  always_comb begin
    st_next = st_reg;
    // reserved bits never set
    set_vec = chg & IMPL;
    // done flag only in one-shot mode
    set_vec[DONE_IDX] = chg[DONE_IDX] & adc_oneshot_mode;
    clr_vec = '0;
    if (rd_en && rd_hit) begin
      // a read clears the byte it returns
      clr_vec[rd_idx*8 +: 8] = 8'hFF;
      st_next.rd_data = st_reg.flags[rd_idx*8 +: 8];
    end else if (rd_en) begin
      // unmapped addresses read zero
      st_next.rd_data = 8'h00;
    end
    // set wins over a read in the same cycle, so no change is lost
    st_next.flags = (st_reg.flags & ~clr_vec) | set_vec;
    // only unmasked flags raise the request
    st_next.int_req = |(st_next.flags & ~mask_all);
  end

  // state register, all flags clear at reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg       <= '0;
      st_reg.flags <= {5{`CEF_FLAG_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  // both outputs come straight from flip-flops, so the host
  // never sees a glitch on the request line
  assign rd_data = st_reg.rd_data;
  assign int_req = st_reg.int_req;

  // reserved bits stay zero
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_reg.flags & ~IMPL) == '0)
    else $error("reserved flag bit set");
  // every change latches one cycle later
  a_change_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
    (set_vec != '0) |=> ((st_reg.flags & $past(set_vec)) == $past(set_vec)))
    else $error("change not latched");
  // flags clear at reset
  a_reset_clear: assert property (@(posedge core_clk)
    $past(sys_rst) |-> (st_reg.flags == '0 && !int_req))
    else $error("flags not clear after reset");
  // read returns the byte held before the read
  a_read_data: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_en && rd_hit) |=> (rd_data == $past(st_reg.flags[rd_idx*8 +: 8])))
    else $error("read data wrong");
  // a read of byte 1Ah clears it unless a change arrives
  a_read_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_en && rd_addr == `CEF_OFS_FLAG3 && set_vec[23:16] == 8'h00)
    |=> (st_reg.flags[23:16] == 8'h00))
    else $error("read did not clear");
  // without a read or change a flag holds
  a_flag_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!rd_en && set_vec == '0) |=> $stable(st_reg.flags))
    else $error("flag changed without cause");
  // interrupt follows unmasked flags
  a_mask_int: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 (int_req == |(st_reg.flags & ~$past(mask_all))))
    else $error("interrupt does not match masked flags");
  // done flag stays quiet in continuous mode
  a_done_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!adc_oneshot_mode && !st_reg.flags[DONE_IDX]) |=> !st_reg.flags[DONE_IDX])
    else $error("done flag set in continuous mode");
  // unmapped reads answer zero
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_en && !rd_hit) |=> (rd_data == 8'h00))
    else $error("unmapped read not zero");
  // a flag rises only where a change was requested
  a_no_spurious: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> ((st_reg.flags & ~$past(st_reg.flags) & ~$past(set_vec)) == '0))
    else $error("flag rose without a change");
  // read answer stands until the next read
  a_rd_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !rd_en |=> $stable(rd_data))
    else $error("read data moved without a read");
  // continuous mode never requests the done flag
  a_done_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    !adc_oneshot_mode |-> !set_vec[DONE_IDX])
    else $error("done flag requested in continuous mode");
  // with every bit masked the request stays low
  a_all_masked: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mask_all == '1) |=> !int_req)
    else $error("interrupt raised while all masked");
  // an unmasked flag raises the request
  a_unmasked_int: assert property (@(posedge core_clk) disable iff (sys_rst)
    ((st_next.flags & ~mask_all) != '0) |=> int_req)
    else $error("unmasked flag without interrupt");
  // an unmapped read leaves every flag alone
  a_unmapped_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_en && !rd_hit)
    |=> (st_reg.flags == ($past(st_reg.flags) | $past(set_vec))))
    else $error("unmapped read touched flags");

  // main scenarios
  c_int_raise: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(int_req));
  c_set_on_read: cover property (@(posedge core_clk) disable iff (sys_rst)
    rd_en && rd_hit && ((set_vec & clr_vec) != '0));
  c_done_flag: cover property (@(posedge core_clk) disable iff (sys_rst)
    $rose(st_reg.flags[DONE_IDX]));
  c_masked_flag: cover property (@(posedge core_clk) disable iff (sys_rst)
    (st_reg.flags != '0) && !int_req);
  c_unmapped_read: cover property (@(posedge core_clk) disable iff (sys_rst)
    rd_en && !rd_hit);
endmodule // cef_flag_bank
`default_nettype wire

/* File: rtl/cef_pkg.sv */
package cef_pkg;
  // one flag byte
  typedef logic [7:0] cef_byte_t;
  // whole state of the flag bank
  typedef struct packed {
    logic [39:0] flags;   // latched change flags, byte 0 at offset 18h
    cef_byte_t   rd_data; // read answer
    logic        int_req; // interrupt request
  } cef_state_t;
endpackage

/* File: rtl/cef_sync_change.sv */
`timescale 1ns/1ns
`default_nettype none
// three-stage synchroniser with change detect per bit
module cef_sync_change #(
  parameter int W = 40
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // asynchronous live status
  input  wire logic [W-1:0] stat_async,
  // one-cycle change pulses
  output logic      [W-1:0] chg
);
  import cef_pkg::*;

  // stage registers, all in one state word
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stbl; // last accepted level per bit
  } cef_sync_state_t;

  cef_sync_state_t st_reg;  // registered state
  cef_sync_state_t st_next; // next state
  logic [W-1:0]    agree;   // stages two and three agree

  // refuse a zero width
  if (W < 1) begin : g_chk
    $error("cef_sync_change: W must be at least 1");
  end

  // shift chain, s1 feeds only s2; a level counts once s2 and s3 agree
  always_comb begin
    agree        = ~(st_reg.s2 ^ st_reg.s3);
    st_next      = st_reg;
    st_next.s1   = stat_async;
    st_next.s2   = st_reg.s1;
    st_next.s3   = st_reg.s2;
    st_next.stbl = (st_reg.stbl & ~agree) | (st_reg.s3 & agree);
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // a change counts once stages two and three agree on a new level; per bit
  for (genvar i = 0; i < W; i++) begin : g_chg
    assign chg[i] = agree[i] & (st_reg.s3[i] ^ st_reg.stbl[i]);
  end

  // a change pulse takes the new level as the accepted one
  a_chg_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
    (chg != '0) |=> ((st_reg.stbl & $past(chg)) == ($past(st_reg.s3) & $past(chg))))
    else $error("change pulse without level update");
endmodule // cef_sync_change
`default_nettype wire

/* File: verification/cef_flag_bank_test.sv */
`include "cef_consts.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module cef_flag_bank_test;
  import cef_pkg::*;
  logic        core_clk = 1'b0; // 100 ns period
  logic        sys_rst  = 1'b1;
  logic [39:0] st       = '0;   // live status, byte 0 at 18h
  logic [39:0] ms       = '0;   // masks, same order
  logic        oneshot  = 1'b0;
  logic        req      = 1'b0;
  cef_byte_t   addr     = 8'h00;
  cef_byte_t   data, rd_addr, rd_data;
  logic        done, rd_en, int_req;
  int          bad_count = 0;
  int          comparisons = 0;
  cef_byte_t   impl [5] = '{`CEF_IMPL_FLAG1, `CEF_IMPL_FLAG2, `CEF_IMPL_FLAG3,
                            `CEF_IMPL_FLAG4, `CEF_IMPL_FLAG5};
  always #50 core_clk = ~core_clk;
  cef_flag_bank dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .stat_bat_bus_volt(st[7:0]), .stat_bus_current(st[15:8]),
    .stat_input_presence(st[23:16]), .stat_thermal_adc_wd(st[31:24]),
    .stat_converter(st[39:32]), .adc_oneshot_mode(oneshot),
    .mask_bat_bus_volt(ms[7:0]), .mask_bus_current(ms[15:8]),
    .mask_input_presence(ms[23:16]), .mask_thermal_adc_wd(ms[31:24]),
    .mask_converter(ms[39:32]), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .int_req(int_req));
  cef_host_model host_u (.core_clk(core_clk), .sys_rst(sys_rst), .req(req),
    .addr(addr), .data(data), .done(done), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data));
  // verdict and end of run
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one register read through the host model, bounded wait
  task automatic rd(input cef_byte_t a, input cef_byte_t exp);
    int n;
    n = 0;
    @(posedge core_clk);
    req  <= 1'b1;
    addr <= a;
    do begin
      @(negedge core_clk);
      n++;
    end while (done !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    `CHK(data, exp)
    @(posedge core_clk);
    req <= 1'b0;
  endtask
  // let a status change pass the synchroniser
  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'h18 + 8'(i), 8'h00);
    rd(8'h1D, 8'h00);
    `CHK(int_req, 1'b0)
    @(posedge core_clk);
    oneshot <= 1'b1;
    st      <= '1;
    settle();
    `CHK(int_req, 1'b1)
    for (int i = 0; i < 5; i++) rd(8'h18 + 8'(i), impl[i]);
    `CHK(int_req, 1'b0)
    for (int i = 0; i < 5; i++) rd(8'h18 + 8'(i), 8'h00);
    @(posedge core_clk);
    ms <= '1;
    st <= '0;
    settle();
    `CHK(int_req, 1'b0)
    rd(8'h18, 8'hFF);
    @(posedge core_clk);
    ms <= '0;
    settle();
    `CHK(int_req, 1'b1)
    for (int i = 1; i < 5; i++) rd(8'h18 + 8'(i), impl[i]);
    @(posedge core_clk);
    oneshot <= 1'b0;
    st      <= '1;
    settle();
    rd(8'h1B, 8'h7F);
    rd(8'h18, 8'hFF);
    end_sim();
  end
  // watchdog well beyond the 150 or so cycles the sequence needs
  initial begin
    #1000000;
    bad_count++;
    end_sim();
  end
endmodule // cef_flag_bank_test
`default_nettype wire

/* File: verification/cef_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// host side: turns one request into a one-cycle read strobe and returns the byte
module cef_host_model (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // request from the bench
  input  wire logic               req,
  input  wire cef_pkg::cef_byte_t addr,
  output cef_pkg::cef_byte_t      data,
  output logic                    done,
  // read port of the flag bank
  output logic                    rd_en,
  output cef_pkg::cef_byte_t      rd_addr,
  input  wire cef_pkg::cef_byte_t rd_data
);
  logic [1:0] ph; // read phase
  // strobe for one edge, then collect the answer one edge later
  always_ff @(posedge core_clk) begin
    rd_en <= 1'b0;
    done  <= 1'b0;
    if (sys_rst) begin
      ph <= 2'h0;
    end else if (ph == 2'h0 && req) begin
      rd_en   <= 1'b1; // single byte per strobe
      rd_addr <= addr;
      ph      <= 2'h1;
    end else if (ph == 2'h1) begin
      rd_addr <= ~rd_addr; // released address must not look valid
      ph      <= 2'h2;
    end else if (ph == 2'h2) begin
      data <= rd_data;
      done <= 1'b1;
      ph   <= 2'h3;
    end else if (ph == 2'h3 && !req) begin
      ph <= 2'h0;
    end
  end
endmodule // cef_host_model
`default_nettype wire
